/* pkg/lpm_pkg.sv */
// package: constants and types for the low-power mode controller
package lpm_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] LPM_CTRL_OFS = 8'h00;
  localparam logic [7:0] LPM_STAT_OFS = 8'h04;
  localparam logic [7:0] LPM_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] LPM_IRQ_MASK_OFS = 8'h0c;
  // control field positions
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_STBY_BIT = 1;
  localparam int CTRL_LPREG_BIT = 2;
  localparam int CTRL_MON_EN_BIT = 3;
  localparam int CTRL_MON_FALL_BIT = 4;
  localparam int CTRL_MON_RISE_BIT = 5;
  // interrupt status bit positions
  localparam int IRQ_MON_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_STBY_BIT = 2;
  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // oscillator settle time and its count at 10 MHz
  localparam int OSC_SETTLE_NS = 2000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] OSC_SETTLE_CNT = 8'(OSC_SETTLE_CYC);
  localparam int EXT_LINES = 16;

  // power states
  typedef enum logic [2:0] {
    LPM_RUN,
    LPM_SLEEP,
    LPM_STOP,
    LPM_WAKE,
    LPM_STBY
  } lpm_state_e;

  // regulator operating modes
  typedef enum logic [1:0] {
    REG_MAIN,
    REG_LOWPWR,
    REG_OFF
  } lpm_reg_e;

  // clock and power enables toward the rest of the chip
  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic pll_en;
    logic internal_fast_rc_oscillator_en;
    logic external_fast_crystal_oscillator_en;
    logic slow_clk_en;
    logic domain_pwr_en;
    logic retain;
  } lpm_pwr_s;

  // wakeup sources
  typedef struct packed {
    logic [EXT_LINES-1:0] ext_line;
    logic monitor;
    logic rtc_alarm;
    logic usb_wake;
    logic wakeup_pin;
    logic independent_watchdog;
    logic external_reset_pin_n;
  } lpm_wake_s;
endpackage

/* hdl/lpm_ctrl.sv */
// low-power mode controller: sleep, stop and standby sequencing
`timescale 1ns/1ps
`default_nettype none
// How it works
// - sleep gates only core clock
// - any interrupt or event ends sleep
// - stop halts core clocks, pll, oscillators
// - stop keeps registers and sram
// - stop regulator mode chosen by software
// - any external event line ends stop
// - standby powers off domain and oscillators
// - standby loses state except backup
// - reset, watchdog, pin edge, alarm end standby
// - rtc, watchdog and slow clocks keep running
// - regulator main, low-power, off per state
// - regulator enabled straight after reset
// - monitor interrupts on falling, rising or both
module lpm_ctrl (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // processor core request and events
  input wire logic core_sleep_req_i,
  input wire logic core_irq_i,
  // raw wakeup sources (pins and other domains)
  input wire lpm_pkg::lpm_wake_s wake_i,
  // supply monitor comparator output, high while supply below threshold
  input wire logic monitor_below_i,
  // clock and power controls
  output lpm_pkg::lpm_pwr_s pwr_o,
  output lpm_pkg::lpm_reg_e reg_mode_o,
  output logic core_wake_o,
  output logic sysclk_rc_sel_o,
  output logic monitor_en_o,
  output logic irq_o
);
  import lpm_pkg::*;

  // module state apart from the input synchronisers
  typedef struct packed {
    lpm_state_e state;
    logic [5:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] settle;
    logic mon_q;
    logic pin_q;
    logic rc_sel;
    logic [31:0] rdata;
  } lpm_st_s;

  lpm_st_s st_ff;
  lpm_st_s nxt_st;

  // two-flop synchronisers for everything from outside the clock domain
  logic [$bits(lpm_wake_s):0] sync1_ff;
  logic [$bits(lpm_wake_s):0] sync2_ff;
  lpm_wake_s wk;
  logic mon_s;

  // input synchroniser; first stage only feeds the second
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // reset pin idles high, so a cleared stage would look like a reset request
      sync1_ff <= {1'b0, lpm_wake_s'{external_reset_pin_n: 1'b1, default: '0}};
      sync2_ff <= {1'b0, lpm_wake_s'{external_reset_pin_n: 1'b1, default: '0}};
    end else begin
      sync1_ff <= {monitor_below_i, wake_i};
      sync2_ff <= sync1_ff;
    end
  end

  // synchronised views
  always_comb begin
    wk = lpm_wake_s'(sync2_ff[$bits(lpm_wake_s)-1:0]);
    mon_s = sync2_ff[$bits(lpm_wake_s)];
  end

  // derived events
  logic mon_on;
  logic mon_fall_ev;
  logic mon_rise_ev;
  logic pin_rise;
  logic stop_wake;
  logic stby_wake;
  logic wr_hit_ctrl;
  logic wr_hit_stat;
  logic wr_hit_mask;

  // event detection
  always_comb begin
    mon_on = st_ff.ctrl[CTRL_MON_EN_BIT];
    // supply dropping below threshold is a rising comparator edge
    mon_fall_ev = mon_on && mon_s && !st_ff.mon_q && st_ff.ctrl[CTRL_MON_FALL_BIT];
    mon_rise_ev = mon_on && !mon_s && st_ff.mon_q && st_ff.ctrl[CTRL_MON_RISE_BIT];
    pin_rise = wk.wakeup_pin && !st_ff.pin_q;
    // any event line, monitor output, alarm or usb ends stop
    stop_wake = (|wk.ext_line) || (mon_on && mon_s) || wk.rtc_alarm || wk.usb_wake;
    stby_wake = !wk.external_reset_pin_n || wk.independent_watchdog || pin_rise || wk.rtc_alarm;
    wr_hit_ctrl = reg_wr_i && (reg_addr_i == LPM_CTRL_OFS);
    wr_hit_stat = reg_wr_i && (reg_addr_i == LPM_IRQ_STAT_OFS);
    wr_hit_mask = reg_wr_i && (reg_addr_i == LPM_IRQ_MASK_OFS);
  end

  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.mon_q = mon_s;
    nxt_st.pin_q = wk.wakeup_pin;
    // register writes
    if (wr_hit_ctrl) begin
      nxt_st.ctrl = reg_wdata_i[5:0];
    end
    if (wr_hit_mask) begin
      nxt_st.irq_mask = reg_wdata_i[2:0];
    end
    // write one clears; a set in the same cycle wins below
    if (wr_hit_stat) begin
      nxt_st.irq_stat = st_ff.irq_stat & ~reg_wdata_i[2:0];
    end
    if (mon_fall_ev || mon_rise_ev) begin
      nxt_st.irq_stat[IRQ_MON_BIT] = 1'b1;
    end
    // power sequencer
    case (st_ff.state)
      LPM_RUN: begin
        if (core_sleep_req_i && st_ff.ctrl[CTRL_STBY_BIT]) begin
          nxt_st.state = LPM_STBY;
          // rc is switched off, so it no longer drives the system clock
          nxt_st.rc_sel = 1'b0;
        end else if (core_sleep_req_i && st_ff.ctrl[CTRL_STOP_BIT]) begin
          nxt_st.state = LPM_STOP;
          // selection comes back only once the rc has settled on wake
          nxt_st.rc_sel = 1'b0;
        end else if (core_sleep_req_i) begin
          nxt_st.state = LPM_SLEEP;
        end
      end
      LPM_SLEEP: begin
        // any interrupt or event returns to run
        if (core_irq_i || stop_wake) begin
          nxt_st.state = LPM_RUN;
        end
      end
      LPM_STOP: begin
        if (stop_wake) begin
          nxt_st.state = LPM_WAKE;
          nxt_st.settle = OSC_SETTLE_CNT;
          nxt_st.irq_stat[IRQ_WAKE_BIT] = 1'b1;
        end
      end
      LPM_WAKE: begin
        // core held until the restarted rc oscillator settles
        if (st_ff.settle <= 8'h01) begin
          nxt_st.state = LPM_RUN;
          nxt_st.rc_sel = 1'b1;
          nxt_st.ctrl[CTRL_STOP_BIT] = 1'b0;
        end else begin
          nxt_st.settle = st_ff.settle - 8'h01;
        end
      end
      LPM_STBY: begin
        // exit is a fresh start: domain state is lost
        if (stby_wake) begin
          nxt_st.state = LPM_RUN;
          nxt_st.ctrl = CTRL_RST;
          nxt_st.irq_mask = IRQ_RST;
          nxt_st.irq_stat = IRQ_RST;
          nxt_st.irq_stat[IRQ_STBY_BIT] = 1'b1;
          nxt_st.rc_sel = 1'b1;
        end
      end
      default: begin
        nxt_st.state = LPM_RUN;
      end
    endcase
    // read data, valid the cycle after the strobe
    nxt_st.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        LPM_CTRL_OFS: nxt_st.rdata = {26'h000_0000, st_ff.ctrl};
        LPM_STAT_OFS: nxt_st.rdata = {28'h000_0000, st_ff.rc_sel, st_ff.state};
        LPM_IRQ_STAT_OFS: nxt_st.rdata = {29'h0000_0000, st_ff.irq_stat};
        LPM_IRQ_MASK_OFS: nxt_st.rdata = {29'h0000_0000, st_ff.irq_mask};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register; regulator comes up enabled from reset
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '{state: LPM_RUN, ctrl: CTRL_RST, irq_stat: IRQ_RST, irq_mask: IRQ_RST,
                 settle: 8'h00, mon_q: 1'b0, pin_q: 1'b0, rc_sel: 1'b1, rdata: 32'h0000_0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // clock, oscillator and power enables per state
  always_comb begin
    pwr_o = '{core_clk_en: 1'b1, periph_clk_en: 1'b1, pll_en: 1'b1,
              internal_fast_rc_oscillator_en: 1'b1, external_fast_crystal_oscillator_en: 1'b1,
              slow_clk_en: 1'b1, domain_pwr_en: 1'b1, retain: 1'b1};
    reg_mode_o = REG_MAIN;
    case (st_ff.state)
      LPM_SLEEP: begin
        pwr_o.core_clk_en = 1'b0;
      end
      LPM_STOP: begin
        pwr_o.core_clk_en = 1'b0;
        pwr_o.periph_clk_en = 1'b0;
        pwr_o.pll_en = 1'b0;
        pwr_o.internal_fast_rc_oscillator_en = 1'b0;
        pwr_o.external_fast_crystal_oscillator_en = 1'b0;
        pwr_o.retain = 1'b1;
        // software picks low-power or normal regulation
        reg_mode_o = st_ff.ctrl[CTRL_LPREG_BIT] ? REG_LOWPWR : REG_MAIN;
      end
      LPM_WAKE: begin
        // rc restarting, everything else still off, core held
        pwr_o.core_clk_en = 1'b0;
        pwr_o.periph_clk_en = 1'b0;
        pwr_o.pll_en = 1'b0;
        pwr_o.external_fast_crystal_oscillator_en = 1'b0;
      end
      LPM_STBY: begin
        pwr_o.core_clk_en = 1'b0;
        pwr_o.periph_clk_en = 1'b0;
        pwr_o.pll_en = 1'b0;
        pwr_o.internal_fast_rc_oscillator_en = 1'b0;
        pwr_o.external_fast_crystal_oscillator_en = 1'b0;
        pwr_o.domain_pwr_en = 1'b0;
        pwr_o.retain = 1'b0;
        reg_mode_o = REG_OFF;
      end
      default: begin
        reg_mode_o = REG_MAIN;
      end
    endcase
    // slow clocks for rtc and watchdog never stop
    pwr_o.slow_clk_en = 1'b1;
  end

  // outputs
  always_comb begin
    core_wake_o = (st_ff.state == LPM_RUN);
    sysclk_rc_sel_o = st_ff.rc_sel;
    monitor_en_o = st_ff.ctrl[CTRL_MON_EN_BIT];
    irq_o = |(st_ff.irq_stat & st_ff.irq_mask);
    reg_rdata_o = st_ff.rdata;
  end
endmodule
`default_nettype wire

/* verif/lpm_ctrl_asserts.sv */
// checker: port-level assertions for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_asserts
  import lpm_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // core and wakeup inputs
  input wire logic core_irq_i,
  input wire lpm_pkg::lpm_wake_s wake_i,
  // controls watched
  input wire lpm_pkg::lpm_pwr_s pwr_o,
  input wire lpm_pkg::lpm_reg_e reg_mode_o,
  input wire logic core_wake_o,
  input wire logic sysclk_rc_sel_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // stop seen at the ports: powered, peripherals and rc halted
  wire logic in_stop;
  assign in_stop = pwr_o.domain_pwr_en && !pwr_o.periph_clk_en && !pwr_o.internal_fast_rc_oscillator_en;
  // core stays halted for at least 8 cycles while the oscillator settles
  sequence s_held;
    !core_wake_o [*8];
  endsequence
  a_sleep_only_core: assert property (!pwr_o.core_clk_en && pwr_o.pll_en |-> pwr_o.periph_clk_en)
    else $error("sleep stopped peripheral clocks");
  a_sleep_irq_wake: assert property (!pwr_o.core_clk_en && pwr_o.pll_en && core_irq_i |-> ##[1:3] core_wake_o)
    else $error("interrupt did not end sleep");
  a_stop_clocks_off: assert property (reg_mode_o == REG_LOWPWR |-> in_stop && !pwr_o.pll_en)
    else $error("clocks running in stop");
  a_stop_keeps_state: assert property (in_stop |-> pwr_o.retain && !pwr_o.external_fast_crystal_oscillator_en)
    else $error("stop lost retention");
  a_stop_line_wake: assert property (in_stop && (|wake_i.ext_line) |-> ##[1:4] pwr_o.internal_fast_rc_oscillator_en)
    else $error("event line did not end stop");
  a_stby_all_off: assert property (reg_mode_o == REG_OFF |-> !pwr_o.domain_pwr_en && !pwr_o.pll_en && !pwr_o.retain)
    else $error("standby left power on");
  a_stop_rc_clear: assert property (in_stop |-> !sysclk_rc_sel_o)
    else $error("rc still selected in stop");
  a_slow_clk_on: assert property (pwr_o.slow_clk_en)
    else $error("slow clocks stopped");
  a_run_main_reg: assert property (core_wake_o |-> reg_mode_o == REG_MAIN && pwr_o.core_clk_en)
    else $error("run without main regulation");
  a_reset_reg_up: assert property (disable iff (1'h0) !resetn_i && !$past(resetn_i) |-> reg_mode_o == REG_MAIN && pwr_o.domain_pwr_en)
    else $error("regulator off in reset");
  a_wake_settle: assert property ($rose(pwr_o.internal_fast_rc_oscillator_en) && !core_wake_o |-> s_held ##[1:16] (core_wake_o && sysclk_rc_sel_o))
    else $error("stop wake settle wrong");
endmodule
bind lpm_ctrl lpm_ctrl_asserts i_lpm_chk (.core_clk_i, .resetn_i, .core_irq_i, .wake_i, .pwr_o, .reg_mode_o,
  .core_wake_o, .sysclk_rc_sel_o);
`default_nettype wire

/* verif/lpm_core_model.sv */
// partner model: processor core issuing wait-for-interrupt and interrupts
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // bench commands
  input wire logic wfi_i,
  input wire logic int_i,
  // controller side
  input wire logic core_wake_i,
  output logic sleep_req_o,
  output logic irq_o
);
  // request holds until the core is halted, so one wfi is one entry
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_req_o <= 1'h0;
      irq_o <= 1'h0;
    end else begin
      if (wfi_i) begin
        sleep_req_o <= 1'h1;
      end else if (!core_wake_i) begin
        sleep_req_o <= 1'h0;
      end
      irq_o <= int_i;
    end
  end
endmodule
`default_nettype wire

/* verif/lpm_ctrl_test.sv */
// testbench: register and power-mode sequences for the low-power controller
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_test;
  import lpm_pkg::*;
  logic core_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic wfi = 1'h0;
  logic intr = 1'h0;
  logic below = 1'h0;
  lpm_wake_s wk;
  logic [31:0] rdata;
  lpm_pwr_s pwr;
  lpm_reg_e rmode;
  logic wake, rc_sel, mon_en, irq, req, cirq;
  int n_fail = 0;
  int n_tests = 0;
  int k;
  always #50 core_clk_i = ~core_clk_i;
  lpm_core_model i_core (.clk_i(core_clk_i), .resetn_i(resetn_i), .wfi_i(wfi), .int_i(intr),
    .core_wake_i(wake), .sleep_req_o(req), .irq_o(cirq));
  lpm_ctrl i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .core_sleep_req_i(req), .core_irq_i(cirq),
    .wake_i(wk), .monitor_below_i(below), .pwr_o(pwr), .reg_mode_o(rmode), .core_wake_o(wake),
    .sysclk_rc_sel_o(rc_sel), .monitor_en_o(mon_en), .irq_o(irq));
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge core_clk_i);
    wr <= 1'h0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge core_clk_i);
    rd <= 1'h0;
    #1 chk("rdata", rdata, exp);
  endtask
  task automatic wfi_seq();
    @(posedge core_clk_i);
    wfi <= 1'h1;
    @(posedge core_clk_i);
    wfi <= 1'h0;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded wait for the core to run again
  task automatic wait_wake();
    for (int i = 0; i < 200 && wake !== 1'h1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk("wake", 32'(wake), 32'h0000_0001);
    if (wake !== 1'h1) stop_test();
  endtask
  initial begin
    wk = '0;
    wk.external_reset_pin_n = 1'h1;
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'h1;
    rd_reg(LPM_STAT_OFS, 32'h0000_0008);
    rd_reg(8'h10, 32'h0000_0000);
    // sleep halts only the core, an interrupt ends it
    wfi_seq();
    chk("core_clk", 32'(pwr.core_clk_en), 32'h0000_0000);
    chk("periph", 32'(pwr.periph_clk_en), 32'h0000_0001);
    intr <= 1'h1;
    wait_wake();
    intr <= 1'h0;
    // an rtc alarm alone also ends sleep
    wfi_seq();
    chk("core_clk", 32'(pwr.core_clk_en), 32'h0000_0000);
    wk.rtc_alarm <= 1'h1;
    wait_wake();
    wk.rtc_alarm <= 1'h0;
    // stop with each regulator choice, one source each
    for (k = 0; k < 3; k++) begin
      wr_reg(LPM_CTRL_OFS, (k == 0) ? 32'h0000_0005 : 32'h0000_0001);
      wfi_seq();
      chk("mode", 32'(rmode), (k == 0) ? 32'(REG_LOWPWR) : 32'(REG_MAIN));
      chk("pll", 32'(pwr.pll_en), 32'h0000_0000);
      chk("retain", 32'(pwr.retain), 32'h0000_0001);
      chk("rc_osc", 32'(pwr.internal_fast_rc_oscillator_en), 32'h0000_0000);
      chk("xtal", 32'(pwr.external_fast_crystal_oscillator_en), 32'h0000_0000);
      chk("rc_sel", 32'(rc_sel), 32'h0000_0000);
      chk("slow", 32'(pwr.slow_clk_en), 32'h0000_0001);
      wk.ext_line[15] <= (k == 0);
      wk.rtc_alarm <= (k == 1);
      wk.usb_wake <= (k == 2);
      repeat (8) @(posedge core_clk_i);
      #1 chk("held", 32'(wake), 32'h0000_0000);
      wait_wake();
      chk("rc_sel", 32'(rc_sel), 32'h0000_0001);
      wk <= '{external_reset_pin_n: 1'h1, default: '0};
      rd_reg(LPM_IRQ_STAT_OFS, 32'h0000_0002);
      rd_reg(LPM_CTRL_OFS, (k == 0) ? 32'h0000_0004 : 32'h0000_0000);
    end
    // masked then unmasked interrupt, cleared by writing one
    chk("irq", 32'(irq), 32'h0000_0000);
    wr_reg(LPM_IRQ_MASK_OFS, 32'h0000_0002);
    chk("irq", 32'(irq), 32'h0000_0001);
    wr_reg(LPM_IRQ_STAT_OFS, 32'h0000_0002);
    chk("irq", 32'(irq), 32'h0000_0000);
    // standby left by each exit source
    for (k = 0; k < 4; k++) begin
      wr_reg(LPM_CTRL_OFS, 32'h0000_0002);
      wfi_seq();
      chk("mode", 32'(rmode), 32'(REG_OFF));
      chk("power", 32'(pwr.domain_pwr_en), 32'h0000_0000);
      chk("pll", 32'(pwr.pll_en), 32'h0000_0000);
      chk("retain", 32'(pwr.retain), 32'h0000_0000);
      wk.wakeup_pin <= (k == 0);
      wk.independent_watchdog <= (k == 1);
      wk.rtc_alarm <= (k == 2);
      wk.external_reset_pin_n <= (k != 3);
      wait_wake();
      wk <= '{external_reset_pin_n: 1'h1, default: '0};
      rd_reg(LPM_IRQ_STAT_OFS, 32'h0000_0004);
      rd_reg(LPM_CTRL_OFS, 32'h0000_0000);
    end
    // monitor silent until enabled, then each edge choice
    wr_reg(LPM_CTRL_OFS, 32'h0000_0010);
    below <= 1'h1;
    repeat (4) @(posedge core_clk_i);
    chk("mon_en", 32'(mon_en), 32'h0000_0000);
    rd_reg(LPM_IRQ_STAT_OFS, 32'h0000_0004);
    wr_reg(LPM_CTRL_OFS, 32'h0000_0028);
    chk("mon_en", 32'(mon_en), 32'h0000_0001);
    below <= 1'h0;
    repeat (4) @(posedge core_clk_i);
    rd_reg(LPM_IRQ_STAT_OFS, 32'h0000_0005);
    wr_reg(LPM_IRQ_STAT_OFS, 32'h0000_0005);
    wr_reg(LPM_CTRL_OFS, 32'h0000_0018);
    below <= 1'h1;
    repeat (4) @(posedge core_clk_i);
    rd_reg(LPM_IRQ_STAT_OFS, 32'h0000_0001);
    // both crossings armed together
    wr_reg(LPM_IRQ_STAT_OFS, 32'h0000_0001);
    wr_reg(LPM_CTRL_OFS, 32'h0000_0038);
    below <= 1'h0;
    repeat (4) @(posedge core_clk_i);
    rd_reg(LPM_IRQ_STAT_OFS, 32'h0000_0001);
    wr_reg(LPM_IRQ_STAT_OFS, 32'h0000_0001);
    below <= 1'h1;
    repeat (4) @(posedge core_clk_i);
    rd_reg(LPM_IRQ_STAT_OFS, 32'h0000_0001);
    wr_reg(LPM_IRQ_MASK_OFS, 32'h0000_0001);
    chk("irq", 32'(irq), 32'h0000_0001);
    stop_test();
  end
endmodule
`default_nettype wire
